// [shared/irq_enable_pkg.sv]
// package: register map, field positions and carriers for the enable bank
package irq_enable_pkg;

   // ------------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_ENABLE_TWO   = 8'h00;
   localparam logic [7:0] OFF_ENABLE_THREE = 8'h04;
   localparam logic [7:0] OFF_ENABLE_FOUR  = 8'h08;
   localparam logic [7:0] OFF_EVENT_STATUS = 8'h0c;
   localparam logic [7:0] OFF_EVENT_MASK   = 8'h10;
   localparam logic [7:0] OFF_GATED_STATE  = 8'h14;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int BIT_SERIAL_EVENT   = 1;
   localparam int BIT_SERIAL_FAULT   = 0;
   localparam int BIT_CALENDAR       = 14;
   localparam int BIT_DMA_FIVE       = 13;
   localparam int BIT_EXT_FOUR       = 6;
   localparam int BIT_EXT_THREE      = 5;
   localparam int BIT_I2C_MASTER     = 2;
   localparam int BIT_I2C_SLAVE      = 1;
   localparam int BIT_CHARGE_TIME    = 13;
   localparam int BIT_VOLTAGE_DETECT = 8;
   localparam int BIT_CHECKSUM       = 3;
   localparam int BIT_UART_TWO_ERR   = 2;
   localparam int BIT_UART_ONE_ERR   = 1;

   // writable-bit masks and reset values
   localparam logic [15:0] MASK_TWO   = 16'h0003;
   localparam logic [15:0] MASK_THREE = 16'h6066;
   localparam logic [15:0] MASK_FOUR  = 16'h210e;
   localparam logic [15:0] RESET_ENABLE = 16'h0000;
   localparam logic [12:0] RESET_EVENT  = 13'h0000;

   localparam int NUM_SOURCES = 13;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic serial_port_two_event;
      logic serial_port_two_fault;
      logic calendar;
      logic dma_channel_five;
      logic external_four;
      logic external_three;
      logic i2c_two_master_event;
      logic i2c_two_slave_event;
      logic charge_time_unit;
      logic voltage_detect;
      logic checksum_generator;
      logic uart_two_error;
      logic uart_one_error;
   } irq_vector_t;

   typedef struct packed {
      logic [15:0] word_two;
      logic [15:0] word_three;
      logic [15:0] word_four;
   } enable_words_t;

endpackage : irq_enable_pkg

// [rtl/irq_gate.sv]
// gate of request lines by enables with sticky event capture
`timescale 1ns/1ps
module irq_gate
   import irq_enable_pkg::*;
#(
   parameter int WIDTH = NUM_SOURCES
)
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // request, enable and gated result
   input  wire logic [WIDTH-1:0] request,
   input  wire logic [WIDTH-1:0] enable,
   output logic      [WIDTH-1:0] gated,
   // sticky capture of gated rises, write-one-to-clear
   input  wire logic [WIDTH-1:0] clear,
   output logic      [WIDTH-1:0] sticky
);

   // refuse widths that the status read-back cannot carry
   if (WIDTH < 1 || WIDTH > 32)
   begin : g_bad_width
      $error("irq_gate: WIDTH must be 1..32");
   end

   logic [WIDTH-1:0] gated_prev;
   logic [WIDTH-1:0] next_sticky;

   // ------------------------------------------------------------------
   // per-source gating
   // ------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_src
         assign gated[i] = request[i] & enable[i];
         // set wins over a clear in the same cycle
         assign next_sticky[i] = (gated[i] & ~gated_prev[i]) | (sticky[i] & ~clear[i]);
      end
   endgenerate

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         gated_prev <= '0;
         sticky     <= '0;
      end
      else
      begin
         gated_prev <= gated;
         sticky     <= next_sticky;
      end
   end

endmodule : irq_gate

// [rtl/irq_enable_bank.sv]
// enable words two to four of the interrupt controller, on an axi4-lite slave
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

module irq_enable_bank
   import irq_enable_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // interrupt requests in and gated requests out
   input  wire irq_vector_t irq_request,
   output irq_vector_t      irq_gated,
   output enable_words_t    enable_words,
   output logic             irq
);

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ------------------------------------------------------------------
   // elaboration checks: the masks must match the enable positions
   // ------------------------------------------------------------------
   if ($bits(irq_vector_t) != NUM_SOURCES)
   begin : g_bad_count
      $error("irq_enable_bank: source count differs from the request vector");
   end

   if (MASK_TWO != ((16'h0001 << BIT_SERIAL_EVENT) | (16'h0001 << BIT_SERIAL_FAULT)))
   begin : g_bad_mask_two
      $error("irq_enable_bank: word two mask disagrees with its enable positions");
   end

   if (MASK_THREE != ((16'h0001 << BIT_CALENDAR) | (16'h0001 << BIT_DMA_FIVE) | (16'h0001 << BIT_EXT_FOUR)
                    | (16'h0001 << BIT_EXT_THREE) | (16'h0001 << BIT_I2C_MASTER) | (16'h0001 << BIT_I2C_SLAVE)))
   begin : g_bad_mask_three
      $error("irq_enable_bank: word three mask disagrees with its enable positions");
   end

   if (MASK_FOUR != ((16'h0001 << BIT_CHARGE_TIME) | (16'h0001 << BIT_VOLTAGE_DETECT) | (16'h0001 << BIT_CHECKSUM)
                   | (16'h0001 << BIT_UART_TWO_ERR) | (16'h0001 << BIT_UART_ONE_ERR)))
   begin : g_bad_mask_four
      $error("irq_enable_bank: word four mask disagrees with its enable positions");
   end

   // ------------------------------------------------------------------
   // register state
   // ------------------------------------------------------------------
   logic [15:0] word_two;
   logic [15:0] word_three;
   logic [15:0] word_four;
   logic [12:0] event_mask;
   logic [15:0] next_word_two;
   logic [15:0] next_word_three;
   logic [15:0] next_word_four;
   logic [12:0] next_event_mask;

   // ------------------------------------------------------------------
   // write channel state
   // ------------------------------------------------------------------
   logic        aw_held;
   logic [7:0]  aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        bvalid;
   logic [1:0]  bresp;
   logic        next_aw_held;
   logic [7:0]  next_aw_addr;
   logic        next_w_held;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_bvalid;
   logic [1:0]  next_bresp;

   // ------------------------------------------------------------------
   // read channel state
   // ------------------------------------------------------------------
   logic        rvalid;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;

   irq_vector_t enable_vec;
   irq_vector_t gated_vec;
   logic [12:0] event_status;
   logic [12:0] event_clear;
   logic        do_write;
   logic [15:0] wmask;

   // ------------------------------------------------------------------
   // enable vector from the words
   // ------------------------------------------------------------------
   always_comb
   begin
      enable_vec.serial_port_two_event = word_two[BIT_SERIAL_EVENT];
      enable_vec.serial_port_two_fault = word_two[BIT_SERIAL_FAULT];
      enable_vec.calendar              = word_three[BIT_CALENDAR];
      enable_vec.dma_channel_five      = word_three[BIT_DMA_FIVE];
      // pin mapping of the external inputs is done outside this block
      enable_vec.external_four         = word_three[BIT_EXT_FOUR];
      enable_vec.external_three        = word_three[BIT_EXT_THREE];
      enable_vec.i2c_two_master_event  = word_three[BIT_I2C_MASTER];
      enable_vec.i2c_two_slave_event   = word_three[BIT_I2C_SLAVE];
      enable_vec.charge_time_unit      = word_four[BIT_CHARGE_TIME];
      enable_vec.voltage_detect        = word_four[BIT_VOLTAGE_DETECT];
      enable_vec.checksum_generator    = word_four[BIT_CHECKSUM];
      enable_vec.uart_two_error        = word_four[BIT_UART_TWO_ERR];
      enable_vec.uart_one_error        = word_four[BIT_UART_ONE_ERR];
   end

   irq_gate #(
      .WIDTH (NUM_SOURCES)
   ) u_gate (
      .core_clk (core_clk),
      .rst      (rst),
      .request  (irq_request),
      .enable   (enable_vec),
      .gated    (gated_vec),
      .clear    (event_clear),
      .sticky   (event_status)
   );

   assign irq_gated    = gated_vec;
   assign enable_words = '{word_two: word_two, word_three: word_three, word_four: word_four};
   assign irq          = |(event_status & event_mask);

   // ------------------------------------------------------------------
   // write path
   // ------------------------------------------------------------------
   assign do_write = aw_held && w_held && !bvalid;
   assign wmask    = {{8{w_strb[1]}}, {8{w_strb[0]}}};

   always_comb
   begin
      next_aw_held    = aw_held;
      next_aw_addr    = aw_addr;
      next_w_held     = w_held;
      next_w_data     = w_data;
      next_w_strb     = w_strb;
      next_bvalid     = bvalid;
      next_bresp      = bresp;
      next_word_two   = word_two;
      next_word_three = word_three;
      next_word_four  = word_four;
      next_event_mask = event_mask;
      event_clear     = '0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = RESP_OKAY;
         unique case (aw_addr)
            OFF_ENABLE_TWO:
               next_word_two = (word_two & ~(wmask & MASK_TWO)) | (w_data[15:0] & wmask & MASK_TWO);
            OFF_ENABLE_THREE:
               next_word_three = (word_three & ~(wmask & MASK_THREE))
                               | (w_data[15:0] & wmask & MASK_THREE);
            OFF_ENABLE_FOUR:
               next_word_four = (word_four & ~(wmask & MASK_FOUR)) | (w_data[15:0] & wmask & MASK_FOUR);
            OFF_EVENT_STATUS:
               event_clear = w_data[12:0] & {{5{w_strb[1]}}, {8{w_strb[0]}}};
            OFF_EVENT_MASK:
               next_event_mask = (event_mask & ~{{5{w_strb[1]}}, {8{w_strb[0]}}})
                               | (w_data[12:0] & {{5{w_strb[1]}}, {8{w_strb[0]}}});
            OFF_GATED_STATE:
               next_bresp = RESP_OKAY;
            default:
               next_bresp = RESP_SLVERR;
         endcase
      end
      if (bvalid && s_axi_bready)
         next_bvalid = 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         aw_held    <= 1'b0;
         aw_addr    <= 8'h00;
         w_held     <= 1'b0;
         w_data     <= 32'h0000_0000;
         w_strb     <= 4'h0;
         bvalid     <= 1'b0;
         bresp      <= RESP_OKAY;
         word_two   <= RESET_ENABLE;
         word_three <= RESET_ENABLE;
         word_four  <= RESET_ENABLE;
         event_mask <= RESET_EVENT;
      end
      else
      begin
         aw_held    <= next_aw_held;
         aw_addr    <= next_aw_addr;
         w_held     <= next_w_held;
         w_data     <= next_w_data;
         w_strb     <= next_w_strb;
         bvalid     <= next_bvalid;
         bresp      <= next_bresp;
         word_two   <= next_word_two;
         word_three <= next_word_three;
         word_four  <= next_word_four;
         event_mask <= next_event_mask;
      end
   end

   assign s_axi_awready = !aw_held && !bvalid;
   assign s_axi_wready  = !w_held && !bvalid;
   assign s_axi_bvalid  = bvalid;
   assign s_axi_bresp   = bresp;

   // ------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------
   always_comb
   begin
      next_rvalid = rvalid;
      next_rdata  = rdata;
      next_rresp  = rresp;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         unique case (s_axi_araddr)
            OFF_ENABLE_TWO:   next_rdata = {16'h0000, word_two & MASK_TWO};
            OFF_ENABLE_THREE: next_rdata = {16'h0000, word_three & MASK_THREE};
            OFF_ENABLE_FOUR:  next_rdata = {16'h0000, word_four & MASK_FOUR};
            OFF_EVENT_STATUS: next_rdata = {19'h00000, event_status};
            OFF_EVENT_MASK:   next_rdata = {19'h00000, event_mask};
            OFF_GATED_STATE:  next_rdata = {19'h00000, gated_vec};
            default:
            begin
               next_rdata = 32'h0000_0000;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid && s_axi_rready)
         next_rvalid = 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= RESP_OKAY;
      end
      else
      begin
         rvalid <= next_rvalid;
         rdata  <= next_rdata;
         rresp  <= next_rresp;
      end
   end

   assign s_axi_arready = !rvalid;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rdata   = rdata;
   assign s_axi_rresp   = rresp;

endmodule : irq_enable_bank

// [verif/irq_enable_bank_chk.sv]
// checker: port assertions for the enable bank
`timescale 1ns/1ps
module irq_enable_bank_chk
   import irq_enable_pkg::*;
(
   // clock and reset
   input wire logic          core_clk,
   input wire logic          rst,
   // bus handshakes
   input wire logic          s_axi_arvalid,
   input wire logic          s_axi_arready,
   input wire logic          s_axi_rvalid,
   input wire logic          s_axi_bvalid,
   input wire logic          s_axi_bready,
   // requests and enables
   input wire irq_vector_t   irq_request,
   input wire irq_vector_t   irq_gated,
   input wire enable_words_t enable_words,
   input wire logic          irq
);
   logic [15:0] w3;
   logic [15:0] w4;
   assign w3 = enable_words.word_three;
   assign w4 = enable_words.word_four;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // ----
   // assertions
   // ----
   a_gate_serial:
      assert property (irq_gated[12:11] == (irq_request[12:11] & enable_words.word_two[1:0]))
      else $error("serial gate wrong");
   a_gate_three:
      assert property (irq_gated[10:5] == (irq_request[10:5] & {w3[14:13], w3[6:5], w3[2:1]}))
      else $error("word three gate wrong");
   a_gate_four:
      assert property (irq_gated[4:0] == (irq_request[4:0] & {w4[13], w4[8], w4[3:1]}))
      else $error("word four gate wrong");
   a_three_spare_zero:
      assert property ((w3 & 16'h9f99) == 16'h0000)
      else $error("word three spare bit set");
   a_four_spare_zero:
      assert property ((w4 & 16'hdef1) == 16'h0000)
      else $error("word four spare bit set");
   a_reset_clears:
      assert property (disable iff (1'b0) rst |=> enable_words == '0)
      else $error("enables not cleared by reset");
   a_enable_by_write:
      assert property (!$past(rst) && $changed(enable_words) |-> $rose(s_axi_bvalid))
      else $error("enable changed without write");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   c_irq: cover property (irq);
   c_write: cover property ($rose(s_axi_bvalid));
   c_gated: cover property (|irq_gated);
endmodule : irq_enable_bank_chk

bind irq_enable_bank irq_enable_bank_chk u_chk (.core_clk, .rst, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .irq_request, .irq_gated, .enable_words, .irq);

// [verif/irq_enable_bank_test.sv]
// testbench: register and gating tests of the enable bank
`timescale 1ns/1ps
module irq_enable_bank_test
   import irq_enable_pkg::*;
;
   logic          core_clk = 1'b0;
   logic          rst = 1'b1;
   logic [7:0]    s_axi_awaddr = 8'h00;
   logic [7:0]    s_axi_araddr = 8'h00;
   logic [31:0]   s_axi_wdata = 32'h0;
   logic [3:0]    s_axi_wstrb = 4'hf;
   logic          s_axi_awvalid = 1'b0;
   logic          s_axi_wvalid = 1'b0;
   logic          s_axi_bready = 1'b0;
   logic          s_axi_arvalid = 1'b0;
   logic          s_axi_rready = 1'b0;
   logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic [31:0]   s_axi_rdata;
   irq_vector_t   irq_request = '0;
   irq_vector_t   irq_gated;
   enable_words_t enable_words;
   int            errors = 0;
   int            check_count = 0;
   int            cycles = 0;
   int            bit_tbl [13] = '{1, 2, 3, 8, 13, 1, 2, 5, 6, 13, 14, 0, 1};
   logic [7:0]    a;

   irq_enable_bank dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .irq_request, .irq_gated, .enable_words, .irq);

   always #2.5 core_clk = ~core_clk;

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         $display("timeout");
         print_verdict;
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // ----
   // bus tasks
   // ----
   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge core_clk);
   endtask : wr

   task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      @(posedge core_clk);
   endtask : rd

   // ----
   // tests
   // ----
   initial
   begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(OFF_ENABLE_TWO, 32'h0, 2'h0);
      rd(OFF_ENABLE_THREE, 32'h0, 2'h0);
      rd(OFF_ENABLE_FOUR, 32'h0, 2'h0);
      $display("test reset_values done");
      wr(OFF_ENABLE_TWO, 32'hffffffff, 2'h0);
      wr(OFF_ENABLE_THREE, 32'hffffffff, 2'h0);
      wr(OFF_ENABLE_FOUR, 32'hffffffff, 2'h0);
      rd(OFF_ENABLE_TWO, 32'h3, 2'h0);
      rd(OFF_ENABLE_THREE, 32'h6066, 2'h0);
      rd(OFF_ENABLE_FOUR, 32'h210e, 2'h0);
      chk("word three out", 32'h6066, {16'h0, enable_words.word_three});
      chk("word four out", 32'h210e, {16'h0, enable_words.word_four});
      for (int k = 0; k < 3; k++)
         wr(8'(4 * k), 32'h0, 2'h0);
      s_axi_wstrb <= 4'h2;
      wr(OFF_ENABLE_THREE, 32'hffffffff, 2'h0);
      s_axi_wstrb <= 4'hf;
      rd(OFF_ENABLE_THREE, 32'h6000, 2'h0);
      wr(OFF_ENABLE_THREE, 32'h0, 2'h0);
      $display("test access_masks done");
      irq_request <= '1;
      for (int i = 0; i < 13; i++)
      begin
         a = (i < 5) ? OFF_ENABLE_FOUR : (i < 11) ? OFF_ENABLE_THREE : OFF_ENABLE_TWO;
         wr(a, 32'h1 << bit_tbl[i], 2'h0);
         chk("gated one", {19'h0, 13'h1 << i}, {19'h0, irq_gated});
         wr(a, 32'h0, 2'h0);
         chk("gated off", 32'h0, {19'h0, irq_gated});
      end
      $display("test gating done");
      irq_request <= '0;
      wr(OFF_EVENT_STATUS, 32'h1fff, 2'h0);
      rd(OFF_EVENT_STATUS, 32'h0, 2'h0);
      wr(OFF_ENABLE_FOUR, 32'h2, 2'h0);
      wr(OFF_EVENT_MASK, 32'h1, 2'h0);
      irq_request.uart_one_error <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("irq raised", 32'h1, {31'h0, irq});
      rd(OFF_EVENT_STATUS, 32'h1, 2'h0);
      rd(OFF_GATED_STATE, 32'h1, 2'h0);
      wr(OFF_EVENT_MASK, 32'h0, 2'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(OFF_EVENT_MASK, 32'h1, 2'h0);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      irq_request.uart_one_error <= 1'b0;
      wr(OFF_EVENT_STATUS, 32'h1, 2'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd(OFF_EVENT_STATUS, 32'h0, 2'h0);
      $display("test interrupt done");
      wr(8'h20, 32'hffffffff, 2'h2);
      rd(8'h20, 32'h0, 2'h2);
      rd(OFF_ENABLE_FOUR, 32'h2, 2'h0);
      $display("test unmapped done");
      print_verdict;
   end
endmodule : irq_enable_bank_test
